// ---- iec_pkg.sv ----
// Package for the interrupt edge and port input controller.
// Assumes a 32-bit AXI4-Lite register bus; offsets below are register indices.
package iec_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_STACK_POINTER = 8'h02;
    localparam logic [7:0] IDX_IRQ_ENABLE    = 8'h04;
    localparam logic [7:0] IDX_IRQ_REQUEST   = 8'h05;
    localparam logic [7:0] IDX_EDGE_SELECT   = 8'h0c;
    localparam logic [7:0] IDX_PA_IN_ENABLE  = 8'h0d;
    localparam logic [7:0] IDX_PB_IN_ENABLE  = 8'h0e;
    localparam logic [7:0] IDX_PA_DATA       = 8'h10;
    localparam logic [7:0] IDX_PA_DIRECTION  = 8'h11;
    localparam logic [7:0] IDX_PA_PULLUP     = 8'h12;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_SP   = 8'h00;

    // Implemented bit masks
    localparam logic [7:0] IRQ_MASK   = 8'hd7;
    localparam logic [7:0] EDGE_MASK  = 8'h1f;
    localparam logic [7:0] PA_EN_MASK = 8'hf9;
    localparam logic [7:0] PB_EN_MASK = 8'h81;

    // Request bit positions
    localparam int BIT_TMR3 = 7;
    localparam int BIT_TMR2 = 6;
    localparam int BIT_CMP  = 4;
    localparam int BIT_T16  = 2;
    localparam int BIT_PB0  = 1;
    localparam int BIT_PA   = 0;

    // Edge select field positions
    localparam int ES_T16    = 4;
    localparam int ES_PB0_LO = 2;
    localparam int ES_PA_LO  = 0;

    // Two-bit edge codes
    localparam logic [1:0] EDGE_BOTH = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;

    // Fixed interrupt vector
    localparam logic [15:0] IRQ_VECTOR = 16'h0010;
    localparam logic [7:0]  SP_STEP    = 8'h02;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // Entry / return sequencer, Gray coded along the entry path only
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_PUSH_LO = 3'b001,
        ST_PUSH_HI = 3'b011,
        ST_VECTOR  = 3'b010,
        ST_POP_LO  = 3'b110,
        ST_POP_HI  = 3'b111,
        ST_RESUME  = 3'b101
    } iec_state_t;

endpackage

// ---- iec_top.sv ----
// Interrupt edge select, entry/return sequencer and port input enables.
// Assumes the core pulses its instruction signals for one MCLK cycle, and that
// the stack memory shows read data while its read strobe is high.
//
// Notes on behaviour
// R1 - Sixteen_bit_timer edge bit: 0 rising, 1 falling of the chosen counter bit.
// R2 - Port B bit0 edge field: 00 both, 01 rising, 10 falling, 11 reserved.
// R3 - Port A bit0/bit5 edge field uses the same two-bit encoding.
// R4 - Software writes zero to upper edge bits; edge register is write-only.
// R5 - Interrupt entry saves the program counter to stack at stack pointer.
// R6 - Entry then increases the stack pointer by two.
// R7 - Entry clears the global interrupt enable.
// R8 - Entry fetches next instruction from the fixed vector address.
// R9 - Return reloads counter from stack, decreases pointer by two, resumes.
// R10 - Return sets the global interrupt enable again.
// R11 - Software sets enables, clears flags, then enables globally.
// R12 - Global disable blocks every source regardless of per-source enables.
// R13 - Handler should clear only its own serviced request flag.
// R14 - Software reserves two stack bytes per nesting level, more with pushes.
// R15 - Port A enable bits 7,6 gate input and wake-up; reset 00.
// R16 - Port A enable bit 5 gates input, wake-up and interrupt; reset 0.
// R17 - Port A enable bits 4,3 gate input and wake-up; bits 2,1 reserved.
// R18 - Port A enable bit 0 gates input, wake-up and interrupt; reset 0.
// R19 - Port B enable bit 7 gates input and wake-up; bits 6..1 reserved.
// R20 - Port B enable bit 0 gates input, wake-up and interrupt request.
// R21 - Port A data register: eight read/write bits, reset zero.
// R22 - Port A direction bit: 0 input, 1 output; reset all inputs.
// R23 - Port A pull-up bit enables the pin's pull-up; reset zero.
// R24 - Enable bits: 7 tmr3, 6 tmr2, 4 cmp, 2 t16, 1 pb0, 0 pa.
// R25 - Request flags set by hardware, held until software writes them clear.
// R26 - Flags set by their events even while the enable bit is zero.
// R27 - Interrupt taken only with global enable and an enabled pending flag.
// R28 - Pins synchronised before edge detection; one flag set per transition.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

module iec_top
    import iec_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    // AXI4-Lite write address and data
    input  wire logic [31:0] AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    // AXI4-Lite write response
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read
    input  wire logic [31:0] ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // Event sources
    input  wire logic        T16_SEL_BIT,
    input  wire logic        TMR2_EVENT,
    input  wire logic        TMR3_EVENT,
    input  wire logic        CMP_EVENT,
    // Port pins
    input  wire logic [7:0]  PA_PIN_IN,
    input  wire logic [7:0]  PB_PIN_IN,
    output logic [7:0]       PA_OUT,
    output logic [7:0]       PA_OE,
    output logic [7:0]       PA_PULLUP,
    output logic [7:0]       PA_DIN,
    output logic [7:0]       PB_DIN,
    output logic             WAKE_EVENT,
    // CPU core sequencing
    input  wire logic [15:0] CPU_PC,
    input  wire logic        CPU_BOUNDARY,
    input  wire logic        CPU_ENGINT,
    input  wire logic        CPU_DISGINT,
    input  wire logic        CPU_RETI,
    output logic             CPU_HOLD,
    output logic             CPU_PC_LOAD,
    output logic [15:0]      CPU_PC_NEW,
    output logic             GIE,
    // Stack memory port
    output logic [7:0]       STK_ADDR,
    output logic [7:0]       STK_WDATA,
    output logic             STK_WE,
    output logic             STK_RE,
    input  wire logic [7:0]  STK_RDATA
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Edge qualifier shared by both two-bit pin fields; 11 never fires
    function automatic logic edge_hit(input logic [1:0] mode, input logic rise,
                                      input logic fall);
        edge_hit = ((mode == EDGE_BOTH) & (rise | fall)) |
                   ((mode == EDGE_RISE) & rise) |
                   ((mode == EDGE_FALL) & fall);
    endfunction

    // Register index from a byte address; word-aligned decode only
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = addr[9:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0]  sp_r, sp_nxt;
    logic [7:0]  irq_en_r, irq_en_nxt;
    logic [7:0]  irq_req_r, irq_req_nxt;
    logic [7:0]  edge_sel_r, edge_sel_nxt;
    logic [7:0]  pa_ien_r, pa_ien_nxt;
    logic [7:0]  pb_ien_r, pb_ien_nxt;
    logic [7:0]  pa_data_r, pa_data_nxt;
    logic [7:0]  pa_dir_r, pa_dir_nxt;
    logic [7:0]  pa_pull_r, pa_pull_nxt;
    logic        gie_r, gie_nxt;

    logic        aw_full_r, aw_full_nxt;
    logic        w_full_r, w_full_nxt;
    logic [7:0]  aw_idx_r, aw_idx_nxt;
    logic [7:0]  w_data_r, w_data_nxt;
    logic        w_lane0_r, w_lane0_nxt;
    logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        bvalid_nxt, rvalid_nxt;

    logic [7:0]  pa_s1_r, pa_s2_r, pa_s3_r;
    logic [7:0]  pb_s1_r, pb_s2_r, pb_s3_r;
    logic        t16_prev_r;

    iec_state_t  state_r, state_nxt;
    logic [15:0] pc_save_r, pc_save_nxt;
    logic [7:0]  pop_lo_r, pop_lo_nxt;

    logic        hold_r, pc_load_r, stk_we_r, stk_re_r, wake_r;
    logic [15:0] pc_new_r, pc_new_nxt;
    logic [7:0]  stk_addr_r, stk_addr_nxt, stk_wdata_r, stk_wdata_nxt;
    logic [7:0]  pa_din_r, pb_din_r;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: one write and one read in flight

    wire aw_hs    = AWVALID & awready_r;
    wire w_hs     = WVALID & wready_r;
    wire ar_hs    = ARVALID & arready_r;
    wire do_write = aw_full_r & w_full_r & ~bvalid_r;
    wire wr_en    = do_write & w_lane0_r;
    wire [7:0] wr_idx = aw_idx_r;
    wire [7:0] rd_idx = reg_index(ARADDR);

    // Address and data held until both arrive, in either order
    assign aw_full_nxt = (aw_full_r | aw_hs) & ~do_write;
    assign w_full_nxt  = (w_full_r | w_hs) & ~do_write;
    assign aw_idx_nxt  = aw_hs ? reg_index(AWADDR) : aw_idx_r;
    assign w_data_nxt  = w_hs ? WDATA[7:0] : w_data_r;
    assign w_lane0_nxt = w_hs ? WSTRB[0] : w_lane0_r;
    assign bvalid_nxt  = do_write | (bvalid_r & ~BREADY);
    assign rvalid_nxt  = ar_hs | (rvalid_r & ~RREADY);

    // Known indices answer OKAY; anything else gets DECERR
    wire wr_known = (wr_idx == IDX_STACK_POINTER) | (wr_idx == IDX_IRQ_ENABLE) |
                    (wr_idx == IDX_IRQ_REQUEST) | (wr_idx == IDX_EDGE_SELECT) |
                    (wr_idx == IDX_PA_IN_ENABLE) | (wr_idx == IDX_PB_IN_ENABLE) |
                    (wr_idx == IDX_PA_DATA) | (wr_idx == IDX_PA_DIRECTION) |
                    (wr_idx == IDX_PA_PULLUP);
    assign bresp_nxt = do_write ? (wr_known ? RESP_OKAY : RESP_DECERR) : bresp_r;

    // Read mux; write-only registers read as zero
    logic [7:0] rd_byte;
    logic       rd_known;
    always_comb begin
        rd_byte  = 8'h00;
        rd_known = 1'b1;
        case (rd_idx)
            IDX_STACK_POINTER: rd_byte = sp_r;
            IDX_IRQ_ENABLE:    rd_byte = irq_en_r;
            IDX_IRQ_REQUEST:   rd_byte = irq_req_r;
            IDX_EDGE_SELECT:   rd_byte = 8'h00;                // [R4]
            IDX_PA_IN_ENABLE:  rd_byte = 8'h00;
            IDX_PB_IN_ENABLE:  rd_byte = 8'h00;
            // Output pins read the latch, input pins the gated pad
            IDX_PA_DATA:       rd_byte = (pa_data_r & pa_dir_r) | (pa_din_r & ~pa_dir_r);
            IDX_PA_DIRECTION:  rd_byte = pa_dir_r;
            IDX_PA_PULLUP:     rd_byte = pa_pull_r;
            default:           rd_known = 1'b0;
        endcase
    end
    assign rdata_nxt = ar_hs ? {24'h00_0000, rd_byte} : rdata_r;
    assign rresp_nxt = ar_hs ? (rd_known ? RESP_OKAY : RESP_DECERR) : rresp_r;

    // Bus handshake flops
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            aw_idx_r  <= RST_BYTE;
            w_data_r  <= RST_BYTE;
            w_lane0_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            arready_r <= 1'b0;
            bvalid_r  <= 1'b0;
            rvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
            aw_idx_r  <= aw_idx_nxt;
            w_data_r  <= w_data_nxt;
            w_lane0_r <= w_lane0_nxt;
            awready_r <= ~aw_full_nxt;
            wready_r  <= ~w_full_nxt;
            arready_r <= ~rvalid_nxt;
            bvalid_r  <= bvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            bresp_r   <= bresp_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    // Two stages synchronise, a third keeps the last settled level
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pa_s1_r    <= RST_BYTE;
            pa_s2_r    <= RST_BYTE;
            pa_s3_r    <= RST_BYTE;
            pb_s1_r    <= RST_BYTE;
            pb_s2_r    <= RST_BYTE;
            pb_s3_r    <= RST_BYTE;
            t16_prev_r <= 1'b0;
        end else begin
            pa_s1_r    <= PA_PIN_IN; // [R28]
            pa_s2_r    <= pa_s1_r;
            pa_s3_r    <= pa_s2_r;
            pb_s1_r    <= PB_PIN_IN;
            pb_s2_r    <= pb_s1_r;
            pb_s3_r    <= pb_s2_r;
            t16_prev_r <= T16_SEL_BIT;
        end
    end

    // Disabled pins are cut off before edge logic: no wake, no request
    wire [7:0] pa_gated  = pa_s2_r & pa_ien_r;                  // [R15] [R16] [R17] [R18]
    wire [7:0] pa_gprev  = pa_s3_r & pa_ien_r;
    wire [7:0] pb_gated  = pb_s2_r & pb_ien_r;                  // [R19] [R20]
    wire [7:0] pb_gprev  = pb_s3_r & pb_ien_r;
    wire [7:0] pa_rise   = pa_gated & ~pa_gprev;
    wire [7:0] pa_fall   = ~pa_gated & pa_gprev;
    wire [7:0] pb_rise   = pb_gated & ~pb_gprev;
    wire [7:0] pb_fall   = ~pb_gated & pb_gprev;

    // Shared port A source: bit 0 and bit 5 both feed one flag
    wire pa_evt  = edge_hit(edge_sel_r[ES_PA_LO +: 2], pa_rise[0] | pa_rise[5],
                            pa_fall[0] | pa_fall[5]);           // [R3]
    wire pb0_evt = edge_hit(edge_sel_r[ES_PB0_LO +: 2], pb_rise[0], pb_fall[0]); // [R2]
    wire t16_evt = edge_sel_r[ES_T16] ? (t16_prev_r & ~T16_SEL_BIT)
                                      : (~t16_prev_r & T16_SEL_BIT);             // [R1]

    // Any toggle on an enabled pin wakes the chip
    wire wake_nxt = |(pa_gated ^ pa_gprev) | |(pb_gated ^ pb_gprev);

    ////////////////////////////////////////////////////////////////////////////
    // Request flags and configuration

    // Events set flags regardless of enables
    wire [7:0] irq_set = {TMR3_EVENT, TMR2_EVENT, 1'b0, CMP_EVENT,
                          1'b0, t16_evt, pb0_evt, pa_evt};      // [R24] [R26]

    // A write replaces flags, but an event in the same cycle still lands
    assign irq_req_nxt = (((wr_en & (wr_idx == IDX_IRQ_REQUEST)) ? w_data_r : irq_req_r)
                         | irq_set) & IRQ_MASK;                 // [R25]
    assign irq_en_nxt  = (wr_en & (wr_idx == IDX_IRQ_ENABLE)) ? (w_data_r & IRQ_MASK)
                                                              : irq_en_r;
    assign edge_sel_nxt = (wr_en & (wr_idx == IDX_EDGE_SELECT)) ? (w_data_r & EDGE_MASK)
                                                                : edge_sel_r;
    assign pa_ien_nxt  = (wr_en & (wr_idx == IDX_PA_IN_ENABLE)) ? (w_data_r & PA_EN_MASK)
                                                                : pa_ien_r;
    assign pb_ien_nxt  = (wr_en & (wr_idx == IDX_PB_IN_ENABLE)) ? (w_data_r & PB_EN_MASK)
                                                                : pb_ien_r;
    assign pa_data_nxt = (wr_en & (wr_idx == IDX_PA_DATA)) ? w_data_r : pa_data_r; // [R21]
    assign pa_dir_nxt  = (wr_en & (wr_idx == IDX_PA_DIRECTION)) ? w_data_r : pa_dir_r;
    assign pa_pull_nxt = (wr_en & (wr_idx == IDX_PA_PULLUP)) ? w_data_r : pa_pull_r;

    ////////////////////////////////////////////////////////////////////////////
    // Entry and return sequencer

    // Global enable gates all sources; enables alone never fire
    wire pending = |(irq_req_r & irq_en_r);
    wire take    = (state_r == ST_IDLE) & gie_r & pending & CPU_BOUNDARY; // [R12] [R27]
    wire ret     = (state_r == ST_IDLE) & ~take & CPU_RETI;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = ST_PUSH_LO;
                end else if (ret) begin
                    state_nxt = ST_POP_LO;
                end
            end
            ST_PUSH_LO: state_nxt = ST_PUSH_HI;
            ST_PUSH_HI: state_nxt = ST_VECTOR;
            ST_VECTOR:  state_nxt = ST_IDLE;
            ST_POP_LO:  state_nxt = ST_POP_HI;
            ST_POP_HI:  state_nxt = ST_RESUME;
            ST_RESUME:  state_nxt = ST_IDLE;
            default:    state_nxt = ST_IDLE;
        endcase
    end

    assign pc_save_nxt = take ? CPU_PC : pc_save_r;
    // Low byte is on the bus during its own read strobe
    assign pop_lo_nxt  = (state_r == ST_POP_LO) ? STK_RDATA : pop_lo_r;

    // Stack pointer: sequencer steps take priority over a bus write
    always_comb begin
        sp_nxt = sp_r;
        if (wr_en & (wr_idx == IDX_STACK_POINTER)) begin
            sp_nxt = w_data_r;
        end
        if (state_r == ST_VECTOR) begin
            sp_nxt = sp_r + SP_STEP; // [R6]
        end else if (state_r == ST_RESUME) begin
            sp_nxt = sp_r - SP_STEP; // [R9]
        end
    end

    // Global enable: instructions, entry clears, return sets
    always_comb begin
        gie_nxt = gie_r;
        if (CPU_ENGINT) begin
            gie_nxt = 1'b1;
        end
        if (CPU_DISGINT) begin
            gie_nxt = 1'b0; // [R12]
        end
        if (take) begin
            gie_nxt = 1'b0; // [R7]
        end else if (state_r == ST_RESUME) begin
            gie_nxt = 1'b1; // [R10]
        end
    end

    // Outputs registered from the state being entered
    wire stk_we_nxt  = (state_nxt == ST_PUSH_LO) | (state_nxt == ST_PUSH_HI);  // [R5]
    wire stk_re_nxt  = (state_nxt == ST_POP_LO) | (state_nxt == ST_POP_HI);
    wire pc_load_nxt = (state_nxt == ST_VECTOR) | (state_nxt == ST_RESUME);
    wire hold_nxt    = (state_nxt != ST_IDLE);

    always_comb begin
        stk_addr_nxt  = stk_addr_r;
        stk_wdata_nxt = stk_wdata_r;
        pc_new_nxt    = pc_new_r;
        case (state_nxt)
            ST_PUSH_LO: begin
                stk_addr_nxt  = sp_r;                           // [R5]
                stk_wdata_nxt = CPU_PC[7:0];
            end
            ST_PUSH_HI: begin
                stk_addr_nxt  = sp_r + 8'h01;
                stk_wdata_nxt = pc_save_r[15:8];
            end
            ST_VECTOR:  pc_new_nxt   = IRQ_VECTOR;              // [R8]
            ST_POP_LO:  stk_addr_nxt = sp_r - SP_STEP;          // [R9]
            ST_POP_HI:  stk_addr_nxt = sp_r - 8'h01;
            ST_RESUME:  pc_new_nxt   = {STK_RDATA, pop_lo_r}; // [R9]
            default:    pc_new_nxt   = pc_new_r;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State flops

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r     <= ST_IDLE;
            pc_save_r   <= 16'h0000;
            pop_lo_r    <= RST_BYTE;
            sp_r        <= RST_SP;
            gie_r       <= 1'b0;
            irq_en_r    <= RST_BYTE;
            irq_req_r   <= RST_BYTE;
            edge_sel_r  <= RST_BYTE;
            pa_ien_r    <= RST_BYTE;
            pb_ien_r    <= RST_BYTE;
            pa_data_r   <= RST_BYTE;
            pa_dir_r    <= RST_BYTE;                            // [R22]
            pa_pull_r   <= RST_BYTE;                            // [R23]
            hold_r      <= 1'b0;
            pc_load_r   <= 1'b0;
            pc_new_r    <= 16'h0000;
            stk_we_r    <= 1'b0;
            stk_re_r    <= 1'b0;
            stk_addr_r  <= RST_BYTE;
            stk_wdata_r <= RST_BYTE;
            pa_din_r    <= RST_BYTE;
            pb_din_r    <= RST_BYTE;
            wake_r      <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            pc_save_r   <= pc_save_nxt;
            pop_lo_r    <= pop_lo_nxt;
            sp_r        <= sp_nxt;
            gie_r       <= gie_nxt;
            irq_en_r    <= irq_en_nxt;
            irq_req_r   <= irq_req_nxt;
            edge_sel_r  <= edge_sel_nxt;
            pa_ien_r    <= pa_ien_nxt;
            pb_ien_r    <= pb_ien_nxt;
            pa_data_r   <= pa_data_nxt;
            pa_dir_r    <= pa_dir_nxt;
            pa_pull_r   <= pa_pull_nxt;
            hold_r      <= hold_nxt;
            pc_load_r   <= pc_load_nxt;
            pc_new_r    <= pc_new_nxt;
            stk_we_r    <= stk_we_nxt;
            stk_re_r    <= stk_re_nxt;
            stk_addr_r  <= stk_addr_nxt;
            stk_wdata_r <= stk_wdata_nxt;
            pa_din_r    <= pa_gated;
            pb_din_r    <= pb_gated;
            wake_r      <= wake_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign AWREADY    = awready_r;
    assign WREADY     = wready_r;
    assign BVALID     = bvalid_r;
    assign BRESP      = bresp_r;
    assign ARREADY    = arready_r;
    assign RVALID     = rvalid_r;
    assign RDATA      = rdata_r;
    assign RRESP      = rresp_r;
    assign PA_OUT     = pa_data_r;
    assign PA_OE      = pa_dir_r;
    assign PA_PULLUP  = pa_pull_r;
    assign PA_DIN     = pa_din_r;
    assign PB_DIN     = pb_din_r;
    assign WAKE_EVENT = wake_r;
    assign CPU_HOLD   = hold_r;
    assign CPU_PC_LOAD = pc_load_r;
    assign CPU_PC_NEW = pc_new_r;
    assign GIE        = gie_r;
    assign STK_ADDR   = stk_addr_r;
    assign STK_WDATA  = stk_wdata_r;
    assign STK_WE     = stk_we_r;
    assign STK_RE     = stk_re_r;

endmodule

`default_nettype wire

// ---- iec_props.sv ----
// Checker for the entry/return sequencer and read channel of iec_top.
// Assumes it is bound onto iec_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module iec_props (
    // Watched ports
    input wire logic        MCLK, SYS_RST, CPU_HOLD, CPU_PC_LOAD, GIE,
    input wire logic        STK_WE, STK_RE, RVALID, RREADY,
    input wire logic [15:0] CPU_PC_NEW,
    input wire logic [7:0]  STK_ADDR,
    input wire logic [31:0] RDATA
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    ////////////////
    // Entry: push two bytes, then vector; global enable already off
    vec_load_a:
    assert property ($rose(CPU_HOLD) && STK_WE |-> ##2 CPU_PC_LOAD && CPU_PC_NEW == 16'h0010)
        else $error("vector load missing");
    gie_off_a:
    assert property ($rose(CPU_HOLD) && STK_WE |-> !GIE) else $error("enable left on");
    no_take_a:
    assert property (!GIE |=> !($rose(CPU_HOLD) && STK_WE)) else $error("entry while off");
    push_pair_a:
    assert property ($rose(STK_WE) |=> STK_WE && STK_ADDR == $past(STK_ADDR) + 8'h01)
        else $error("push order wrong");
    pop_pair_a:
    assert property ($rose(STK_RE) |=> STK_RE && STK_ADDR == $past(STK_ADDR) + 8'h01)
        else $error("pop order wrong");
    ret_load_a:
    assert property ($rose(CPU_HOLD) && STK_RE |-> ##2 CPU_PC_LOAD ##1 GIE)
        else $error("return incomplete");
    // Core stall covers the three busy steps
    hold_len_a:
    assert property ($rose(CPU_HOLD) |-> CPU_HOLD[*3] ##1 !CPU_HOLD) else $error("stall length");
    rd_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped");
endmodule
bind iec_top iec_props chk (.*);
`default_nettype wire

// ---- iec_stack_model.sv ----
// Stack area of data memory as the core side sees it.
// Assumes read data is wanted while the read strobe is high.
`timescale 1ns/10ps
`default_nettype none
module iec_stack_model (
    // Memory port
    input wire logic        clk, we, re,
    input wire logic [7:0]  addr, wdata,
    output logic [7:0]      rdata
);
    logic [7:0] mem [256];
    logic       tgl = 1'b0;
    // Writes land at the edge; unread cycles show a moving pattern, not stale data
    always @(posedge clk) begin
        tgl <= ~tgl;
        if (we) mem[addr] <= wdata;
    end
    assign rdata = re ? mem[addr] : {4{tgl, ~tgl}};
endmodule
`default_nettype wire

// ---- iec_top_tb.sv ----
// Testbench: registers, interrupt entry/return and pin requests of iec_top.
// Assumes the stack model stands in for the data memory.
`timescale 1ns/10ps
`default_nettype none
module iec_top_tb;
    import iec_pkg::*;
    logic MCLK = 0, SYS_RST = 1, AWVALID = 0, WVALID = 0, BREADY = 1, ARVALID = 0, RREADY = 1;
    logic T16_SEL_BIT = 0, CPU_BOUNDARY = 1, CPU_ENGINT = 0, CPU_DISGINT = 0, CPU_RETI = 0;
    logic TMR2_EVENT = 0, TMR3_EVENT = 0, CMP_EVENT = 0, AWREADY, WREADY, BVALID, ARREADY;
    logic RVALID, WAKE_EVENT, CPU_HOLD, CPU_PC_LOAD, GIE, STK_WE, STK_RE;
    logic [31:0] AWADDR = '0, WDATA = '0, ARADDR = '0, RDATA;
    logic [7:0]  PA_PIN_IN = '0, PB_PIN_IN = '0, PA_OUT, PA_OE, PA_PULLUP, PA_DIN, PB_DIN;
    logic [7:0]  STK_ADDR, STK_WDATA, STK_RDATA;
    logic [15:0] CPU_PC = 16'h1234, CPU_PC_NEW;
    logic [3:0]  WSTRB = 4'hf;
    logic [1:0]  BRESP, RRESP;
    int          bad_count = 0, samples_checked = 0;
    iec_top dut (.*);
    iec_stack_model stk (.clk(MCLK), .we(STK_WE), .re(STK_RE), .addr(STK_ADDR),
        .wdata(STK_WDATA), .rdata(STK_RDATA));
    always #20 MCLK = ~MCLK;
    ////////////////
    task automatic chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Bus write: both channels offered together, each released once taken
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        AWADDR <= {22'h0, i, 2'b00};
        WDATA <= {24'h0, d};
        AWVALID <= 1;
        WVALID <= 1;
        do begin
            @(posedge MCLK);
            if (AWREADY) AWVALID <= 0;
            if (WREADY) WVALID <= 0;
        end while (AWVALID || WVALID);
        do @(posedge MCLK); while (BVALID !== 1'b1);
        chk(BRESP, RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic [1:0] r);
        ARADDR <= {22'h0, i, 2'b00};
        ARVALID <= 1;
        do @(posedge MCLK); while (ARREADY !== 1'b1);
        ARVALID <= 0;
        do @(posedge MCLK); while (RVALID !== 1'b1);
        chk(RDATA, e);
        chk(RRESP, r);
    endtask
    task automatic t_regs();
        rd(IDX_PA_DIRECTION, 0, RESP_OKAY);
        rd(IDX_PA_PULLUP, 0, RESP_OKAY);
        wr(IDX_PA_DIRECTION, 8'ha5);
        wr(IDX_PA_DATA, 8'h3c);
        wr(IDX_PA_PULLUP, 8'h0f);
        chk(PA_OE, 8'ha5);
        chk(PA_OUT, 8'h3c);
        chk(PA_PULLUP, 8'h0f);
        wr(IDX_EDGE_SELECT, 8'h1f);
        rd(IDX_EDGE_SELECT, 0, RESP_OKAY);
        rd(8'h3f, 0, RESP_DECERR);
    endtask
    task automatic t_irq();
        wr(IDX_STACK_POINTER, 8'h40);
        wr(IDX_EDGE_SELECT, 8'h10);
        wr(IDX_IRQ_ENABLE, 8'h04);
        wr(IDX_IRQ_REQUEST, 8'h00);
        CPU_ENGINT <= 1;
        @(posedge MCLK);
        CPU_ENGINT <= 0;
        T16_SEL_BIT <= 1;
        repeat (4) @(posedge MCLK);
        chk(CPU_HOLD, 0);
        T16_SEL_BIT <= 0;
        do @(posedge MCLK); while (CPU_PC_LOAD !== 1'b1);
        chk(CPU_PC_NEW, IRQ_VECTOR);
        chk(GIE, 0);
        chk({stk.mem[8'h41], stk.mem[8'h40]}, 16'h1234);
        rd(IDX_STACK_POINTER, 8'h42, RESP_OKAY);
        wr(IDX_IRQ_REQUEST, 8'h00);
        CPU_RETI <= 1;
        @(posedge MCLK);
        CPU_RETI <= 0;
        do @(posedge MCLK); while (CPU_PC_LOAD !== 1'b1);
        chk(CPU_PC_NEW, 16'h1234);
        @(posedge MCLK);
        chk(GIE, 1);
        rd(IDX_STACK_POINTER, 8'h40, RESP_OKAY);
    endtask
    // Pins 0 and 5 rise with only pin 0 enabled; timer 3 fires while masked
    task automatic t_pin();
        CPU_DISGINT <= 1;
        @(posedge MCLK);
        CPU_DISGINT <= 0;
        wr(IDX_IRQ_ENABLE, 8'h01);
        wr(IDX_EDGE_SELECT, 8'h01);
        wr(IDX_PA_IN_ENABLE, 8'h01);
        PA_PIN_IN <= 8'h21;
        TMR3_EVENT <= 1;
        @(posedge MCLK);
        TMR3_EVENT <= 0;
        repeat (3) @(posedge MCLK);
        chk(WAKE_EVENT, 1);
        repeat (2) @(posedge MCLK);
        chk(PA_DIN, 8'h01);
        rd(IDX_IRQ_REQUEST, 8'h81, RESP_OKAY);
        chk(CPU_HOLD, 0);
    endtask
    task automatic conclude();
        $display("checks %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100us;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge MCLK);
        SYS_RST <= 0;
        @(posedge MCLK);
        t_regs();
        t_irq();
        t_pin();
        conclude();
    end
endmodule
`default_nettype wire
